/* include/bcx_regs.svh */
`ifndef BCX_REGS_SVH
`define BCX_REGS_SVH
// 12-bit instruction encodings (baseline word layout), status bit positions and reset values
`define BCX_OP6_INC_FILE  6'b001010
`define BCX_OP6_DEC_SKIP  6'b001011
`define BCX_OP6_INC_SKIP  6'b001111
`define BCX_OP6_OR_FILE   6'b000100
`define BCX_OP7_STORE   7'b0000001
`define BCX_OP3_JUMP    3'b101
`define BCX_OP4_ORLIT   4'b1101
`define BCX_STAT_PA_HI  6
`define BCX_STAT_PA_LO  5
`define BCX_STAT_Z      2
`define BCX_ACC_RST     8'h00
`define BCX_PC_RST      11'h7ff
`endif

/* include/bcx_pkg.sv */
package bcx_pkg;
  typedef enum logic [1:0] {
    BCX_RUN   = 2'b00,
    BCX_FLUSH = 2'b01
  } bcx_state_t;

  typedef struct packed {
    logic       we;
    logic [4:0] addr;
    logic [7:0] data;
  } bcx_fwr_t;

  typedef struct packed {
    bcx_state_t state;
    logic [7:0] acc;
    logic       zero;
    logic       zeroWe;
    logic [10:0] pc;
    logic       pcLoad;
    logic       busy;
    bcx_fwr_t   fwr;
  } bcx_st_t;
endpackage

/* hdl/bcx_exec.sv */
`timescale 1ns/1ps
`include "bcx_regs.svh"
// Operation
// - increment file: f+1 to acc (d=0) or f (d=1), zero flag updated
// - decrement-skip: f-1 to acc or f by d, flags untouched
// - decrement-skip zero result: discard fetched next word, run nop
// - increment-skip: f+1 to acc or f by d, flags untouched
// - increment-skip zero result: discard prefetched word, two cycles
// - jump: k to pc<8:0>, status<6:5> to pc<10:9>
// - jump unconditional, two cycles, flags untouched
// - or literal: acc | k into acc, zero flag updated
// - or with file: acc | f to acc or f by d, zero flag updated
// - store accumulator: acc into file f, no flag change
module bcx_exec (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              insnValid,
  input  wire logic [11:0]       insn,
  input  wire logic [7:0]        fileRdData,
  input  wire logic [7:0]        status,
  output logic [4:0]             fileRdAddr,
  output bcx_pkg::bcx_fwr_t      fileWr,
  output logic [7:0]             acc,
  output logic                   zeroFlag,
  output logic                   zeroWe,
  output logic [10:0]            pcLoadValue,
  output logic                   pcLoad,
  output logic                   busy
);
  logic             rstMeta;
  logic             rstSync;
  bcx_pkg::bcx_st_t s_q;
  bcx_pkg::bcx_st_t s_d;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  function automatic logic isZero(input logic [7:0] v);
    return v == 8'h00;
  endfunction

  // file read address is combinational from the word so data is same cycle
  assign fileRdAddr = insn[4:0];

  logic [7:0] incRes;
  logic [7:0] decRes;
  logic [7:0] orFile;
  logic       dBit;
  logic [7:0] skipRes;
  assign incRes  = fileRdData + 8'h01;
  assign decRes  = fileRdData - 8'h01;
  assign orFile  = s_q.acc | fileRdData;
  assign dBit    = insn[5];
  assign skipRes = (insn[8]) ? incRes : decRes;

  always_comb begin
    s_d          = s_q;
    s_d.fwr.we   = 1'b0;
    s_d.fwr.addr = insn[4:0];
    s_d.zeroWe   = 1'b0;
    s_d.pcLoad   = 1'b0;
    s_d.busy     = 1'b0;
    s_d.state    = bcx_pkg::BCX_RUN;
    unique case (s_q.state)
      bcx_pkg::BCX_FLUSH: begin
        // prefetched word is dropped; this cycle acts as a nop
      end
      bcx_pkg::BCX_RUN: begin
        if (insnValid) begin
          if (insn[11:6] == `BCX_OP6_INC_FILE) begin
            s_d.fwr.we   = dBit;
            s_d.fwr.data = incRes;
            if (!dBit) s_d.acc = incRes;
            s_d.zero     = isZero(incRes);
            s_d.zeroWe   = 1'b1;
          end else if (insn[11:6] == `BCX_OP6_DEC_SKIP ||
                       insn[11:6] == `BCX_OP6_INC_SKIP) begin
            s_d.fwr.we   = dBit;
            s_d.fwr.data = skipRes;
            if (!dBit) s_d.acc = skipRes;
            if (isZero(skipRes)) begin
              s_d.state = bcx_pkg::BCX_FLUSH;
              s_d.busy  = 1'b1;
            end
          end else if (insn[11:6] == `BCX_OP6_OR_FILE) begin
            s_d.fwr.we   = dBit;
            s_d.fwr.data = orFile;
            if (!dBit) s_d.acc = orFile;
            s_d.zero     = isZero(orFile);
            s_d.zeroWe   = 1'b1;
          end else if (insn[11:5] == `BCX_OP7_STORE) begin
            s_d.fwr.we   = 1'b1;
            s_d.fwr.data = s_q.acc;
          end else if (insn[11:9] == `BCX_OP3_JUMP) begin
            s_d.pc = {status[`BCX_STAT_PA_HI:`BCX_STAT_PA_LO],
                      insn[8:0]};
            s_d.pcLoad = 1'b1;
            s_d.busy   = 1'b1;
            s_d.state  = bcx_pkg::BCX_FLUSH;
          end else if (insn[11:8] == `BCX_OP4_ORLIT) begin
            s_d.acc    = s_q.acc | insn[7:0];
            s_d.zero   = isZero(s_q.acc | insn[7:0]);
            s_d.zeroWe = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      s_q <= '{state: bcx_pkg::BCX_RUN, acc: `BCX_ACC_RST, zero: 1'b0,
               zeroWe: 1'b0, pc: `BCX_PC_RST, pcLoad: 1'b0, busy: 1'b0,
               fwr: '{we: 1'b0, addr: 5'h00, data: 8'h00}};
    end else begin
      s_q <= s_d;
    end
  end

  assign fileWr      = s_q.fwr;
  assign acc         = s_q.acc;
  assign zeroFlag    = s_q.zero;
  assign zeroWe      = s_q.zeroWe;
  assign pcLoadValue = s_q.pc;
  assign pcLoad      = s_q.pcLoad;
  assign busy        = s_q.busy;

  default clocking dc @(posedge clk);
  endclocking
  // checks stay quiet until the synchronised reset has let go
  default disable iff (!rstSync);

  // zero result worked out from the operand, not from the datapath
  sequence skipTaken;
    insnValid && s_q.state == bcx_pkg::BCX_RUN &&
    (insn[11:6] == `BCX_OP6_DEC_SKIP || insn[11:6] == `BCX_OP6_INC_SKIP) &&
    (insn[8] ? fileRdData == 8'hff : fileRdData == 8'h01);
  endsequence
  sequence flushCycle;
    s_q.state == bcx_pkg::BCX_FLUSH ##1 s_q.state == bcx_pkg::BCX_RUN;
  endsequence
  sequence flushPulse;
    busy ##1 !busy;
  endsequence

  a_skip_flush: assert property (skipTaken |=> flushCycle)
    else $error("skip did not flush next word");

  a_skip_two: assert property (
    skipTaken |=> flushPulse)
    else $error("skip not two cycles");

  a_flush_nowr: assert property (
    s_q.state == bcx_pkg::BCX_FLUSH |=> !fileWr.we && !zeroWe && !pcLoad)
    else $error("flushed word had effect");

  a_skip_noz: assert property (
    insnValid && s_q.state == bcx_pkg::BCX_RUN &&
    insn[11:6] == `BCX_OP6_DEC_SKIP |=> !zeroWe)
    else $error("decrement-skip touched zero flag");

  a_incsz_noz: assert property (
    insnValid && s_q.state == bcx_pkg::BCX_RUN &&
    insn[11:6] == `BCX_OP6_INC_SKIP |=> !zeroWe)
    else $error("increment-skip touched zero flag");

  a_dec_route: assert property (
    insnValid && s_q.state == bcx_pkg::BCX_RUN &&
    insn[11:6] == `BCX_OP6_DEC_SKIP && insn[5] |=>
    fileWr.we && fileWr.data == $past(fileRdData) - 8'h01 &&
    fileWr.addr == $past(insn[4:0]))
    else $error("decrement-skip did not write file");

  a_inc_dest: assert property (
    insnValid && s_q.state == bcx_pkg::BCX_RUN &&
    insn[11:6] == `BCX_OP6_INC_FILE && insn[5] |=>
    fileWr.we && fileWr.data == $past(fileRdData) + 8'h01)
    else $error("increment did not write file");

  a_inc_acc: assert property (
    insnValid && s_q.state == bcx_pkg::BCX_RUN &&
    insn[11:6] == `BCX_OP6_INC_FILE && !insn[5] |=>
    acc == $past(fileRdData) + 8'h01 && !fileWr.we && zeroWe &&
    zeroFlag == (acc == 8'h00))
    else $error("increment to accumulator wrong");

  a_incsz_acc: assert property (
    insnValid && s_q.state == bcx_pkg::BCX_RUN &&
    insn[11:6] == `BCX_OP6_INC_SKIP && !insn[5] |=>
    acc == $past(fileRdData) + 8'h01 && !fileWr.we)
    else $error("increment-skip result misrouted");

  a_jump_pc: assert property (
    insnValid && s_q.state == bcx_pkg::BCX_RUN &&
    insn[11:9] == `BCX_OP3_JUMP |=>
    pcLoad && pcLoadValue == {$past(status[6:5]), $past(insn[8:0])})
    else $error("jump target wrong");

  a_jump_two: assert property (
    pcLoad |-> busy && !zeroWe ##1 !pcLoad && !busy)
    else $error("jump not two cycles");

  a_orlit_z: assert property (
    insnValid && s_q.state == bcx_pkg::BCX_RUN &&
    insn[11:8] == `BCX_OP4_ORLIT |=>
    acc == ($past(acc) | $past(insn[7:0])) && zeroWe &&
    zeroFlag == (acc == 8'h00))
    else $error("or literal wrong");

  a_orfile_w: assert property (
    insnValid && s_q.state == bcx_pkg::BCX_RUN &&
    insn[11:6] == `BCX_OP6_OR_FILE && insn[5] |=>
    fileWr.we && fileWr.data == ($past(acc) | $past(fileRdData)))
    else $error("or with file wrong");

  a_orfile_acc: assert property (
    insnValid && s_q.state == bcx_pkg::BCX_RUN &&
    insn[11:6] == `BCX_OP6_OR_FILE && !insn[5] |=>
    acc == ($past(acc) | $past(fileRdData)) && !fileWr.we && zeroWe &&
    zeroFlag == (acc == 8'h00))
    else $error("or with file to accumulator wrong");

  a_store_acc: assert property (
    insnValid && s_q.state == bcx_pkg::BCX_RUN &&
    insn[11:5] == `BCX_OP7_STORE |=>
    fileWr.we && fileWr.data == $past(acc) && !zeroWe)
    else $error("store wrong");

  a_store_keep: assert property (
    insnValid && s_q.state == bcx_pkg::BCX_RUN &&
    insn[11:5] == `BCX_OP7_STORE |=>
    acc == $past(acc) && fileWr.addr == $past(insn[4:0]))
    else $error("store changed accumulator or address");

  a_plain_one: assert property (zeroWe |-> !busy)
    else $error("plain op stalled");
endmodule

/* dv/bcx_file_model.sv */
`timescale 1ns/1ps
`include "bcx_regs.svh"
module bcx_file_model (
  input  wire logic              clk,
  input  wire logic [4:0]        fileRdAddr,
  input  wire bcx_pkg::bcx_fwr_t fileWr,
  input  wire logic              zeroWe,
  input  wire logic              zeroFlag,
  output logic [7:0]             fileRdData,
  output logic [7:0]             status
);
  logic [7:0] mem [32];
  initial status = 8'h00;
  // operand read is same-cycle, so no wait state on the core's fetch path
  assign fileRdData = mem[fileRdAddr];
  always @(posedge clk) begin
    if (fileWr.we) mem[fileWr.addr] <= fileWr.data;
    if (zeroWe) status[`BCX_STAT_Z] <= zeroFlag;
  end
  task automatic put(input logic [4:0] a, input logic [7:0] v);
    mem[a] = v;
  endtask
endmodule

/* dv/testbench.sv */
`timescale 1ns/1ps
`include "bcx_regs.svh"
module testbench;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              insnValid = 1'b0;
  logic [11:0]       insn = 12'h000;
  logic [7:0]        fileRdData, status, acc;
  logic [4:0]        fileRdAddr;
  bcx_pkg::bcx_fwr_t fileWr;
  logic              zeroFlag, zeroWe, pcLoad, busy;
  logic [10:0]       pcLoadValue;
  int                errors = 0;
  int                compares = 0;
  int                cycles = 0;
  always #5 clk = ~clk;
  bcx_exec u_dut (.clk(clk), .rst_n(rst_n), .insnValid(insnValid),
    .insn(insn), .fileRdData(fileRdData), .status(status),
    .fileRdAddr(fileRdAddr), .fileWr(fileWr), .acc(acc),
    .zeroFlag(zeroFlag), .zeroWe(zeroWe), .pcLoadValue(pcLoadValue),
    .pcLoad(pcLoad), .busy(busy));
  bcx_file_model u_mem (.clk(clk), .fileRdAddr(fileRdAddr),
    .fileWr(fileWr), .zeroWe(zeroWe), .zeroFlag(zeroFlag),
    .fileRdData(fileRdData), .status(status));
  task automatic wrap_up;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string n, input logic [25:0] e,
                     input logic [25:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // nx is what the fetch path offers in the cycle after w is taken
  task automatic ex(input logic [11:0] w, input logic v,
                    input logic [11:0] nx);
    @(negedge clk);
    insn = w;
    insnValid = v;
    @(negedge clk);
    insn = nx;
    insnValid = 1'b1;
  endtask
  // write data and zero flag are masked by their strobes
  task automatic res(input logic [7:0] a, input logic w, input logic [4:0] ad,
                     input logic [7:0] d, input logic zw, input logic z,
                     input logic b);
    chk("results", {a, w, ad, d, zw, z, b, 1'b0},
        {acc, fileWr.we, fileWr.addr & {5{fileWr.we}},
         fileWr.data & {8{fileWr.we}}, zeroWe, zeroFlag & zeroWe, busy,
         pcLoad});
  endtask
  task automatic t_increment_file_reg;
    u_mem.put(5'h03, 8'hff);
    u_mem.put(5'h04, 8'h41);
    ex({`BCX_OP6_INC_FILE, 1'b1, 5'h03}, 1'b1, 12'h000);
    res(8'h00, 1'b1, 5'h03, 8'h00, 1'b1, 1'b1, 1'b0);
    ex({`BCX_OP6_INC_FILE, 1'b0, 5'h04}, 1'b1, 12'h000);
    res(8'h42, 1'b0, 5'h00, 8'h00, 1'b1, 1'b0, 1'b0);
    ex({`BCX_OP6_INC_FILE, 1'b0, 5'h04}, 1'b0, 12'h000);
    res(8'h42, 1'b0, 5'h00, 8'h00, 1'b0, 1'b0, 1'b0);
  endtask
  task automatic t_skip;
    u_mem.put(5'h05, 8'h01);
    u_mem.put(5'h06, 8'h03);
    u_mem.put(5'h07, 8'hff);
    ex({`BCX_OP6_DEC_SKIP, 1'b0, 5'h05}, 1'b1, {`BCX_OP4_ORLIT, 8'h0f});
    res(8'h00, 1'b0, 5'h00, 8'h00, 1'b0, 1'b0, 1'b1);
    ex(12'h000, 1'b1, 12'h000);
    res(8'h00, 1'b0, 5'h00, 8'h00, 1'b0, 1'b0, 1'b0);
    ex({`BCX_OP6_DEC_SKIP, 1'b1, 5'h06}, 1'b1, 12'h000);
    res(8'h00, 1'b1, 5'h06, 8'h02, 1'b0, 1'b0, 1'b0);
    ex({`BCX_OP6_INC_SKIP, 1'b1, 5'h07}, 1'b1, {`BCX_OP4_ORLIT, 8'h01});
    res(8'h00, 1'b1, 5'h07, 8'h00, 1'b0, 1'b0, 1'b1);
    ex(12'h000, 1'b1, 12'h000);
    res(8'h00, 1'b0, 5'h00, 8'h00, 1'b0, 1'b0, 1'b0);
  endtask
  task automatic t_jump;
    u_mem.status[6:5] = 2'b10;
    ex({`BCX_OP3_JUMP, 9'h1a5}, 1'b1, {`BCX_OP4_ORLIT, 8'hff});
    chk("jump", {12'h000, 1'b0, 1'b1, 1'b1, 11'h5a5},
        {12'h000, zeroWe, pcLoad, busy, pcLoadValue});
    ex(12'h000, 1'b1, 12'h000);
    res(8'h00, 1'b0, 5'h00, 8'h00, 1'b0, 1'b0, 1'b0);
  endtask
  task automatic t_or;
    u_mem.put(5'h09, 8'h86);
    ex({`BCX_OP4_ORLIT, 8'h00}, 1'b1, 12'h000);
    res(8'h00, 1'b0, 5'h00, 8'h00, 1'b1, 1'b1, 1'b0);
    ex({`BCX_OP6_OR_FILE, 1'b1, 5'h09}, 1'b1, 12'h000);
    res(8'h00, 1'b1, 5'h09, 8'h86, 1'b1, 1'b0, 1'b0);
    ex({`BCX_OP6_OR_FILE, 1'b0, 5'h09}, 1'b1, 12'h000);
    res(8'h86, 1'b0, 5'h00, 8'h00, 1'b1, 1'b0, 1'b0);
    ex({`BCX_OP4_ORLIT, 8'h68}, 1'b1, 12'h000);
    res(8'hee, 1'b0, 5'h00, 8'h00, 1'b1, 1'b0, 1'b0);
    ex({`BCX_OP7_STORE, 5'h0a}, 1'b1, 12'h000);
    res(8'hee, 1'b1, 5'h0a, 8'hee, 1'b0, 1'b0, 1'b0);
    insn = {`BCX_OP6_OR_FILE, 1'b0, 5'h1f};
    insnValid = 1'b0;
    #1;
    chk("read addr", {21'h0, 5'h1f}, {21'h0, fileRdAddr});
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      wrap_up;
    end
  end
  initial begin
    repeat (6) @(negedge clk);
    res(`BCX_ACC_RST, 1'b0, 5'h00, 8'h00, 1'b0, 1'b0, 1'b0);
    chk("pc reset", {15'h0000, `BCX_PC_RST}, {15'h0000, pcLoadValue});
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    insnValid = 1'b1;
    t_increment_file_reg;
    t_skip;
    t_jump;
    t_or;
    wrap_up;
  end
endmodule
